// *** verilog/scs_clock_select.sv ***
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "scs_clock_map.svh"
module scs_clock_select import scs_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [`SCS_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scsPins_t linePins,
  input wire logic [1:0] txSlotActive,
  output logic [1:0] txClockPinOut,
  output logic [1:0] txClockPinOe,
  output logic crystalOutPin,
  output logic [1:0] rxDomainTick,
  output logic [1:0] txDomainTick,
  output logic [1:0] timerTick,
  output logic [1:0] rxBitEnable,
  output logic [1:0] txBitEnable,
  output logic [1:0] rxFrameSync,
  output logic [1:0] txFrameSync,
  output logic [1:0] carrierDetected
);

  logic [1:0] rstPipeQ;
  logic rstN;
  scsPins_t pinMetaQ;
  scsPins_t pinSyncQ;
  scsPins_t pinLastQ;
  scsChanCfg_t cfgQ [2];
  logic [`SCS_DIV_W-1:0] divLowQ [2];
  logic [`SCS_DIV_W-1:0] divHighQ [2];
  logic oscPowerdownQ;
  logic oscRunning;
  logic oscTick;
  logic [1:0] rxPinRise;
  logic [1:0] txPinRise;
  logic apbSetup;
  logic apbWrite;
  logic addrHit;
  logic [31:0] readMux;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipeQ <= 2'h0;
    end else begin
      rstPipeQ <= {rstPipeQ[0], 1'b1};
    end
  end
  assign rstN = rstPipeQ[1];

  // pins are asynchronous; the third stage only serves edge detection
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pinMetaQ <= '0;
      pinSyncQ <= '0;
      pinLastQ <= '0;
    end else begin
      pinMetaQ <= linePins;
      pinSyncQ <= pinMetaQ;
      pinLastQ <= pinSyncQ;
    end
  end

  assign rxPinRise = pinSyncQ.rxClock & ~pinLastQ.rxClock;
  assign txPinRise = pinSyncQ.txClock & ~pinLastQ.txClock;

  // crystal input accepts a crystal or an external clock; one tick feeds both channels
  assign oscRunning = ~oscPowerdownQ;
  assign oscTick = oscRunning & pinSyncQ.crystalIn & ~pinLastQ.crystalIn; // RULE14

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      crystalOutPin <= 1'b0;
    end else begin
      crystalOutPin <= oscRunning & ~pinSyncQ.crystalIn;
    end
  end

  // apb: zero wait states, answer prepared in the setup cycle
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready & pwrite & addrHit;

  always_comb begin
    addrHit = 1'b1;
    readMux = 32'h0;
    unique case (paddr)
      `SCS_ADDR_CH0_CFG: readMux[`SCS_CFG_W-1:0] = cfgQ[0];
      `SCS_ADDR_CH0_DIVLO: readMux[`SCS_DIV_W-1:0] = divLowQ[0];
      `SCS_ADDR_CH0_DIVHI: readMux[`SCS_DIV_W-1:0] = divHighQ[0];
      `SCS_ADDR_CH1_CFG: readMux[`SCS_CFG_W-1:0] = cfgQ[1];
      `SCS_ADDR_CH1_DIVLO: readMux[`SCS_DIV_W-1:0] = divLowQ[1];
      `SCS_ADDR_CH1_DIVHI: readMux[`SCS_DIV_W-1:0] = divHighQ[1];
      `SCS_ADDR_GLOBAL_MODE_REG: readMux[`SCS_GLOBAL_MODE_REG_OSC_POWERDOWN_BIT] = oscPowerdownQ;
      `SCS_ADDR_STATUS: readMux[`SCS_STATUS_W-1:0] = {oscRunning, txClockPinOe[1], carrierDetected[1],
                                                      txClockPinOe[0], carrierDetected[0]};
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (apbSetup) begin
      pready <= 1'b1;
      pslverr <= ~addrHit;
      prdata <= pwrite ? 32'h0 : readMux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

  // oscillator powerdown set out of reset; software clears it before oscillator modes
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      oscPowerdownQ <= `SCS_GLOBAL_MODE_REG_RESET;
    end else if (apbWrite && paddr == `SCS_ADDR_GLOBAL_MODE_REG) begin
      oscPowerdownQ <= pwdata[`SCS_GLOBAL_MODE_REG_OSC_POWERDOWN_BIT]; // RULE13
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cfgQ[0] <= `SCS_CFG_RESET;
      cfgQ[1] <= `SCS_CFG_RESET;
    end else if (apbWrite && paddr == `SCS_ADDR_CH0_CFG) begin
      cfgQ[0] <= pwdata[`SCS_CFG_W-1:0]; // RULE1
    end else if (apbWrite && paddr == `SCS_ADDR_CH1_CFG) begin
      cfgQ[1] <= pwdata[`SCS_CFG_W-1:0]; // RULE1
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      divLowQ[0] <= `SCS_DIV_RESET;
      divLowQ[1] <= `SCS_DIV_RESET;
      divHighQ[0] <= `SCS_DIV_RESET;
      divHighQ[1] <= `SCS_DIV_RESET;
    end else if (apbWrite) begin
      if (paddr == `SCS_ADDR_CH0_DIVLO) divLowQ[0] <= pwdata[`SCS_DIV_W-1:0];
      if (paddr == `SCS_ADDR_CH1_DIVLO) divLowQ[1] <= pwdata[`SCS_DIV_W-1:0];
      if (paddr == `SCS_ADDR_CH0_DIVHI) divHighQ[0] <= pwdata[`SCS_DIV_W-1:0];
      if (paddr == `SCS_ADDR_CH1_DIVHI) divHighQ[1] <= pwdata[`SCS_DIV_W-1:0];
    end
  end

  function automatic logic pickTick(input scsClkSrc_t sel, input logic rxPin, input logic txPin,
                                    input logic divT, input logic div16T, input logic pllT);
    logic t;
    t = 1'b0;
    unique case (sel)
      SRC_RX_PIN: t = rxPin;
      SRC_TX_PIN: t = txPin;
      SRC_DIV: t = divT;
      SRC_DIV16: t = div16T;
      SRC_PLL: t = pllT;
      SRC_NONE, SRC_OSC: t = 1'b0;
    endcase
    return t;
  endfunction : pickTick

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      scsClkSrc_t rxSel;
      scsClkSrc_t txSel;
      scsClkSrc_t divSel;
      logic outAllowed;
      logic usesCarrier;
      logic divIn;
      logic divTick;
      logic pllTick;
      logic div16Tick;
      logic rxNext;
      logic txNext;
      logic [`SCS_PHASE_W-1:0] preQ;
      scsChanCfg_t cfg;

      assign cfg = cfgQ[ch];

      // mode field plus sub-select: a rows are sub-select 0, b rows 1
      always_comb begin
        rxSel = SRC_RX_PIN;
        txSel = SRC_TX_PIN;
        divSel = SRC_NONE;
        outAllowed = 1'b0;
        usesCarrier = 1'b1;
        unique case (cfg.clockModeField) // RULE2
          `SCS_MODE_0: begin
            if (cfg.subSelect) begin
              divSel = SRC_OSC; // RULE17
              txSel = SRC_DIV;
              outAllowed = 1'b1; // RULE19
            end
          end
          `SCS_MODE_1: begin
            txSel = SRC_RX_PIN; // RULE17
            usesCarrier = 1'b0;
          end
          `SCS_MODE_2, `SCS_MODE_6: begin
            divSel = (cfg.clockModeField == `SCS_MODE_6) ? SRC_OSC : SRC_RX_PIN; // RULE18
            rxSel = SRC_PLL; // RULE12
            if (cfg.subSelect) begin
              txSel = SRC_DIV16; // RULE11
              outAllowed = 1'b1;
            end
          end
          `SCS_MODE_3, `SCS_MODE_7: begin
            divSel = (cfg.clockModeField == `SCS_MODE_7) ? SRC_OSC : SRC_RX_PIN; // RULE17
            outAllowed = 1'b1;
            rxSel = cfg.subSelect ? SRC_DIV : SRC_PLL;
            txSel = cfg.subSelect ? SRC_DIV : SRC_PLL;
          end
          `SCS_MODE_4: begin
            usesCarrier = 1'b0; // RULE18
          end
          `SCS_MODE_5: begin
            usesCarrier = 1'b0;
            if (!cfg.subSelect) begin
              txSel = SRC_RX_PIN; // RULE18
              outAllowed = 1'b1;
            end
          end
        endcase
      end

      assign divIn = (divSel == SRC_OSC) ? oscTick : (divSel == SRC_RX_PIN) ? rxPinRise[ch] : 1'b0; // RULE4

      scs_baud_divider u_div ( // RULE3
        .clk(sys_clk),
        .rstN(rstN),
        .srcTick(divIn),
        .ratio({divHighQ[ch], divLowQ[ch]}), // RULE6
        .outTick(divTick)
      );

      // recovery reference is always this channel's own divider
      scs_clock_recovery u_pll ( // RULE3
        .clk(sys_clk),
        .rstN(rstN),
        .enable(rxSel == SRC_PLL || txSel == SRC_PLL),
        .refTick(divTick), // RULE6
        .rxData(pinSyncQ.rxData[ch]),
        .recTick(pllTick)
      );

      always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          preQ <= `SCS_PHASE_ZERO;
        end else if (divTick) begin
          preQ <= preQ + 1'b1;
        end
      end
      assign div16Tick = divTick & (preQ == `SCS_PHASE_LAST); // RULE11

      assign rxNext = pickTick(rxSel, rxPinRise[ch], txPinRise[ch], divTick, div16Tick, pllTick);
      assign txNext = pickTick(txSel, rxPinRise[ch], txPinRise[ch], divTick, div16Tick, pllTick);

      // domain ticks are internal and need not match pin edges
      always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          rxDomainTick[ch] <= 1'b0;
          txDomainTick[ch] <= 1'b0;
          timerTick[ch] <= 1'b0;
        end else begin
          rxDomainTick[ch] <= rxNext; // RULE7 RULE9
          txDomainTick[ch] <= txNext; // RULE7 RULE9
          timerTick[ch] <= txNext; // RULE8
        end
      end

      // strobes in mode 1, gating in mode 4 (gate high holds the bit), syncs in mode 5
      always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          rxBitEnable[ch] <= 1'b0;
          txBitEnable[ch] <= 1'b0;
          rxFrameSync[ch] <= 1'b0;
          txFrameSync[ch] <= 1'b0;
          carrierDetected[ch] <= 1'b0;
        end else begin
          rxBitEnable[ch] <= (cfg.clockModeField == `SCS_MODE_1) ? pinSyncQ.carrierDetect[ch] :
                             (cfg.clockModeField == `SCS_MODE_4) ? ~pinSyncQ.rxClockGate[ch] : 1'b1; // RULE15
          txBitEnable[ch] <= (cfg.clockModeField == `SCS_MODE_1) ? pinSyncQ.txClock[ch] :
                             (cfg.clockModeField == `SCS_MODE_4) ? ~pinSyncQ.txClockGate[ch] : 1'b1; // RULE15
          if (cfg.clockModeField == `SCS_MODE_5) begin
            rxFrameSync[ch] <= cfg.subSelect ? pinSyncQ.octetSyncRx[ch] : pinSyncQ.frameSync[ch]; // RULE15
            txFrameSync[ch] <= cfg.subSelect ? pinSyncQ.octetSyncTx[ch] : pinSyncQ.frameSync[ch]; // RULE15
          end else begin
            rxFrameSync[ch] <= 1'b0;
            txFrameSync[ch] <= 1'b0;
          end
          carrierDetected[ch] <= usesCarrier & pinSyncQ.carrierDetect[ch];
        end
      end

      // pin idles high while driven so slot control reads low only in the window
      always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          txClockPinOe[ch] <= 1'b0;
          txClockPinOut[ch] <= 1'b0;
        end else begin
          txClockPinOe[ch] <= outAllowed & cfg.txClockOutputEnable; // RULE5
          if (cfg.clockModeField == `SCS_MODE_5) begin
            txClockPinOut[ch] <= ~txSlotActive[ch]; // RULE16
          end else begin
            txClockPinOut[ch] <= txNext; // RULE16 RULE19
          end
        end
      end
    end
  endgenerate

endmodule : scs_clock_select

// *** verilog/scs_clock_map.svh ***
// Notes on behaviour
// RULE1 - each channel offers fourteen clock setups from a 3-bit mode field and sub-select
// RULE2 - suffix a means sub-select 0, suffix b means 1; 6b is mode 6, sub-select 1
// RULE3 - two dividers and two recovery loops, one each per channel, one shared oscillator
// RULE4 - clocks come from pins, oscillator and divider, or recovery from receive data
// RULE5 - output enable bit, in modes allowing it, turns tx clock pin into an output
// RULE6 - recovery loop is fed by its own channel divider; ratio set by low/high registers
// RULE7 - transmit logic and receive logic each get their own domain clock
// RULE8 - channel timers always tick on the internal transmit-domain clock
// RULE9 - domain clocks are internal and may differ from the pin clocks
// RULE10 - recovered receive clock is the recovery reference divided by 16
// RULE11 - mode 6b: transmit is divider output over 16, divider fed by oscillator
// RULE12 - mode 6b: receive comes from the recovery loop fed by the divider
// RULE13 - software should power the oscillator up before choosing modes 0b, 6 or 7
// RULE14 - oscillator serves one or both channels; crystal input may take an external clock
// RULE15 - mode 1 uses bit strobes, mode 4 bit gating, mode 5 frame sync inputs
// RULE16 - driven tx clock pin shows effective transmit clock, or slot control in mode 5
// RULE17 - modes 0 to 3 pick pins, oscillator-fed divider, pin-fed divider and recovery
// RULE18 - mode 4 gated pins, 5a shared pin, 5b octet syncs, 6 and 7 oscillator-fed
// RULE19 - mode 0b drives the divider transmit clock onto the pin when enabled
`ifndef SCS_CLOCK_MAP_SVH
`define SCS_CLOCK_MAP_SVH

`define SCS_ADDR_W 12
`define SCS_ADDR_CH0_CFG 12'h000
`define SCS_ADDR_CH0_DIVLO 12'h004
`define SCS_ADDR_CH0_DIVHI 12'h008
`define SCS_ADDR_CH1_CFG 12'h010
`define SCS_ADDR_CH1_DIVLO 12'h014
`define SCS_ADDR_CH1_DIVHI 12'h018
`define SCS_ADDR_GLOBAL_MODE_REG 12'h020
`define SCS_ADDR_STATUS 12'h024

`define SCS_CFG_W 5
`define SCS_DIV_W 8
`define SCS_RATIO_W 16
`define SCS_CFG_RESET 5'h00
`define SCS_DIV_RESET 8'h00
`define SCS_GLOBAL_MODE_REG_OSC_POWERDOWN_BIT 0
`define SCS_GLOBAL_MODE_REG_RESET 1'h1
`define SCS_STATUS_W 5

`define SCS_MODE_0 3'h0
`define SCS_MODE_1 3'h1
`define SCS_MODE_2 3'h2
`define SCS_MODE_3 3'h3
`define SCS_MODE_4 3'h4
`define SCS_MODE_5 3'h5
`define SCS_MODE_6 3'h6
`define SCS_MODE_7 3'h7

`define SCS_PHASE_W 4
`define SCS_PHASE_LAST 4'hf
`define SCS_PHASE_CENTER 4'h8
`define SCS_PHASE_ZERO 4'h0

`endif

// *** verilog/scs_pkg.sv ***
package scs_pkg;

  // channel clock configuration register layout, high bits first
  typedef struct packed {
    logic txClockOutputEnable;
    logic subSelect;
    logic [2:0] clockModeField;
  } scsChanCfg_t;

  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_RX_PIN,
    SRC_TX_PIN,
    SRC_OSC,
    SRC_DIV,
    SRC_DIV16,
    SRC_PLL
  } scsClkSrc_t;

  // line-side inputs, index is the channel
  typedef struct packed {
    logic crystalIn;
    logic [1:0] rxClock;
    logic [1:0] txClock;
    logic [1:0] carrierDetect;
    logic [1:0] rxClockGate;
    logic [1:0] txClockGate;
    logic [1:0] frameSync;
    logic [1:0] octetSyncTx;
    logic [1:0] octetSyncRx;
    logic [1:0] rxData;
  } scsPins_t;

endpackage : scs_pkg

// *** verilog/scs_baud_divider.sv ***
`timescale 1ns/100ps
`include "scs_clock_map.svh"
module scs_baud_divider import scs_pkg::*; (
  input wire logic clk,
  input wire logic rstN,
  input wire logic srcTick,
  input wire logic [`SCS_RATIO_W-1:0] ratio,
  output logic outTick
);

  logic [`SCS_RATIO_W-1:0] countQ;

  // divides source ticks by ratio+1; ratio 0 passes every tick
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      countQ <= '0;
      outTick <= 1'b0;
    end else if (srcTick) begin
      if (countQ >= ratio) begin
        countQ <= '0;
        outTick <= 1'b1;
      end else begin
        countQ <= countQ + 1'b1;
        outTick <= 1'b0;
      end
    end else begin
      outTick <= 1'b0;
    end
  end

endmodule : scs_baud_divider

// *** verilog/scs_clock_recovery.sv ***
`timescale 1ns/100ps
`include "scs_clock_map.svh"
module scs_clock_recovery import scs_pkg::*; (
  input wire logic clk,
  input wire logic rstN,
  input wire logic enable,
  input wire logic refTick,
  input wire logic rxData,
  output logic recTick
);

  logic [`SCS_PHASE_W-1:0] phaseQ;
  logic lastDataQ;

  // one recovered tick per sixteen reference ticks; data edges re-center phase
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      phaseQ <= `SCS_PHASE_ZERO;
      lastDataQ <= 1'b0;
      recTick <= 1'b0;
    end else if (!enable) begin
      phaseQ <= `SCS_PHASE_ZERO;
      lastDataQ <= rxData;
      recTick <= 1'b0;
    end else if (refTick) begin
      lastDataQ <= rxData;
      recTick <= (phaseQ == `SCS_PHASE_LAST); // RULE10
      if (rxData != lastDataQ) begin
        // edge lands mid-count so sampling sits in the bit centre
        phaseQ <= `SCS_PHASE_CENTER;
      end else begin
        phaseQ <= phaseQ + 1'b1;
      end
    end else begin
      recTick <= 1'b0;
    end
  end

endmodule : scs_clock_recovery

// *** test/scs_clock_select_props.sv ***
`timescale 1ns/100ps
module scs_clock_select_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] txClockPinOe,
  input wire logic [1:0] rxDomainTick,
  input wire logic [1:0] txDomainTick,
  input wire logic [1:0] timerTick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  apb_zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  apb_single_beat_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_answer_cause_a: assert property (pready |-> penable && $past(psel && !penable))
    else $error("pready without setup");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  err_qualified_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  timer_on_tx_a: assert property (timerTick == txDomainTick)
    else $error("timer tick differs from tx tick");
  domain_tick_pulse_a: assert property (rxDomainTick[0] || txDomainTick[1] |=>
    !(rxDomainTick[0] && $past(rxDomainTick[0])) && !(txDomainTick[1] && $past(txDomainTick[1])))
    else $error("domain tick wider than one cycle");
  // the pin only turns round because software rewrote the configuration
  oe_by_write_a: assert property ($changed(txClockPinOe) |->
    $past(pwrite && pready) || $past(pwrite && pready, 2) || $past(pwrite && pready, 3))
    else $error("tx pin direction changed without a write");
endmodule : scs_clock_select_props

bind scs_clock_select scs_clock_select_props props (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txClockPinOe(txClockPinOe), .rxDomainTick(rxDomainTick), .txDomainTick(txDomainTick),
  .timerTick(timerTick));

// *** test/scs_line_model.sv ***
`timescale 1ns/100ps
module scs_line_model import scs_pkg::*; (
  input wire logic sys_clk,
  input wire scsPins_t ctl,
  output scsPins_t pins
);
  int n = 0;
  always @(posedge sys_clk) begin
    n <= n + 1;
  end
  // free running line clocks, each phase at least two system cycles
  always_comb begin
    pins = ctl;
    pins.rxClock = {2{(n % 8) >= 4}};
    pins.txClock = {2{(n % 12) >= 6}};
    pins.crystalIn = (n % 4) >= 2;
  end
endmodule : scs_line_model

// *** test/serial_channel_clock_select_tb.sv ***
`timescale 1ns/100ps
`include "scs_clock_map.svh"
module serial_channel_clock_select_tb import scs_pkg::*;;
  localparam int W = 960;
  localparam logic [15:0] OE_MASK = 16'hcda8;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [`SCS_ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, crystalOutPin;
  scsPins_t ctl = '0;
  scsPins_t linePins;
  logic [1:0] txSlotActive = 2'h0;
  logic [1:0] txClockPinOut, txClockPinOe, rxDomainTick, txDomainTick, timerTick;
  logic [1:0] rxBitEnable, txBitEnable, rxFrameSync, txFrameSync, carrierDetected;
  int errors = 0;
  int numChecks = 0;
  logic xtalPrev;
  int cnt[4] = '{default: 0};
  logic [4:0] cfgT[14] = '{5'h00, 5'h08, 5'h01, 5'h02, 5'h0a, 5'h03, 5'h0b, 5'h04, 5'h05, 5'h0d, 5'h06,
    5'h0e, 5'h07, 5'h0f};
  // expected period in system cycles of each domain tick
  int rxP[14] = '{8, 8, 8, 128, 128, 128, 16, 8, 8, 8, 64, 64, 64, 8};
  int txP[14] = '{12, 4, 8, 12, 128, 128, 16, 12, 8, 12, 12, 64, 64, 8};

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  scs_line_model line (.sys_clk(sys_clk), .ctl(ctl), .pins(linePins));

  scs_clock_select dut (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .linePins(linePins), .txSlotActive(txSlotActive), .txClockPinOut(txClockPinOut),
    .txClockPinOe(txClockPinOe), .crystalOutPin(crystalOutPin), .rxDomainTick(rxDomainTick),
    .txDomainTick(txDomainTick), .timerTick(timerTick), .rxBitEnable(rxBitEnable),
    .txBitEnable(txBitEnable), .rxFrameSync(rxFrameSync), .txFrameSync(txFrameSync),
    .carrierDetected(carrierDetected));

  always @(posedge sys_clk) begin
    for (int i = 0; i < 2; i++) begin
      cnt[i] <= cnt[i] + (rxDomainTick[i] === 1'b1);
      cnt[i + 2] <= cnt[i + 2] + (txDomainTick[i] === 1'b1);
    end
  end

  task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check32

  task automatic checkCnt(input string name, input int exp, input int got);
    numChecks++;
    if (got < exp - 1 || got > exp + 1 || (exp == 0 && got != 0)) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : checkCnt

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait-state count assumed; only the watchdog ends a hung access
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check32(name, exp, r);
    check32({name, " err"}, {31'h0, expErr}, {31'h0, e});
  endtask : rd

  // settle first: recovery loops start from phase zero when a mode change enables them
  task automatic measure(input string name, input int r0, input int t0, input int r1, input int t1);
    int s[4];
    repeat (300) @(posedge sys_clk);
    s = cnt;
    repeat (W) @(posedge sys_clk);
    checkCnt({name, " rx0"}, r0, cnt[0] - s[0]);
    checkCnt({name, " tx0"}, t0, cnt[2] - s[2]);
    checkCnt({name, " rx1"}, r1, cnt[1] - s[1]);
    checkCnt({name, " tx1"}, t1, cnt[3] - s[3]);
  endtask : measure

  task final_report;
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd("cfg0 reset", `SCS_ADDR_CH0_CFG, 32'h0, 1'b0);
    rd("divhi1 reset", `SCS_ADDR_CH1_DIVHI, 32'h0, 1'b0);
    rd("global_mode_reg reset", `SCS_ADDR_GLOBAL_MODE_REG, 32'h1, 1'b0);
    rd("status reset", `SCS_ADDR_STATUS, 32'h0, 1'b0);
    wr(`SCS_ADDR_CH0_CFG, 32'hffffffff);
    rd("cfg0 width", `SCS_ADDR_CH0_CFG, 32'h1f, 1'b0);
    wr(12'h030, 32'h1);
    rd("unmapped", 12'h030, 32'h0, 1'b1);
    wr(`SCS_ADDR_CH0_DIVLO, 32'hcd);
    wr(`SCS_ADDR_CH0_DIVHI, 32'hab);
    rd("divlo0", `SCS_ADDR_CH0_DIVLO, 32'hcd, 1'b0);
    rd("divhi0", `SCS_ADDR_CH0_DIVHI, 32'hab, 1'b0);
    wr(`SCS_ADDR_CH0_DIVHI, 32'h0);
    wr(`SCS_ADDR_CH0_DIVLO, 32'h0);
    wr(`SCS_ADDR_CH0_CFG, 32'h0f);
    measure("osc down", 0, 0, W / 8, W / 12);
    // two samples half a crystal period apart: a running output differs between them
    xtalPrev = crystalOutPin;
    repeat (2) @(posedge sys_clk);
    check32("xtal off", 32'h0, {30'h0, xtalPrev, crystalOutPin});
    wr(`SCS_ADDR_GLOBAL_MODE_REG, 32'h0);
    wr(`SCS_ADDR_CH1_CFG, 32'h1f);
    wr(`SCS_ADDR_CH1_DIVLO, 32'h2);
    xtalPrev = crystalOutPin;
    repeat (2) @(posedge sys_clk);
    check32("xtal on", 32'h1, {31'h0, xtalPrev ^ crystalOutPin});
    for (int i = 0; i < 14; i++) begin
      wr(`SCS_ADDR_CH0_CFG, {27'h0, cfgT[i] | 5'h10});
      wr(`SCS_ADDR_CH0_DIVLO, (cfgT[i] == 5'h0b || cfgT[i] == 5'h0f) ? 32'h1 : 32'h0);
      measure($sformatf("mode row %0d", i), W / rxP[i], W / txP[i], W / 12, W / 12);
      check32("oe0", {31'h0, OE_MASK[cfgT[i][3:0]]}, {31'h0, txClockPinOe[0]});
    end
    wr(`SCS_ADDR_CH0_CFG, 32'h04);
    ctl.txClockGate[0] <= 1'b1;
    ctl.carrierDetect[0] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check32("tx gate", 32'h0, {31'h0, txBitEnable[0]});
    check32("rx gate open", 32'h1, {31'h0, rxBitEnable[0]});
    check32("cd mode 4", 32'h0, {31'h0, carrierDetected[0]});
    wr(`SCS_ADDR_CH0_CFG, 32'h15);
    repeat (8) @(posedge sys_clk);
    check32("slot idle", 32'h1, {31'h0, txClockPinOut[0]});
    txSlotActive <= 2'h1;
    ctl.frameSync[0] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check32("slot pin", 32'h0, {31'h0, txClockPinOut[0]});
    check32("frame sync", 32'h1, {31'h0, rxFrameSync[0]});
    check32("tx frame sync", 32'h1, {31'h0, txFrameSync[0]});
    rd("status", `SCS_ADDR_STATUS, 32'h1a, 1'b0);
    wr(`SCS_ADDR_STATUS, 32'h0);
    rd("status ro", `SCS_ADDR_STATUS, 32'h1a, 1'b0);
    wr(`SCS_ADDR_CH0_CFG, 32'h01);
    repeat (8) @(posedge sys_clk);
    check32("rx strobe", 32'h1, {31'h0, rxBitEnable[0]});
    ctl.carrierDetect[0] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check32("rx strobe low", 32'h0, {31'h0, rxBitEnable[0]});
    ctl.carrierDetect[0] <= 1'b1;
    wr(`SCS_ADDR_CH0_CFG, 32'h00);
    repeat (8) @(posedge sys_clk);
    rd("status cd", `SCS_ADDR_STATUS, 32'h19, 1'b0);
    final_report();
  end
endmodule : serial_channel_clock_select_tb
